// ==== rtl/pfcs_params.svh ====
// Constants of the parallel flash command sequencer host.
`ifndef PFCS_PARAMS_SVH
`define PFCS_PARAMS_SVH
`define PFCS_UNLOCK_ADDR_A   16'h5555
`define PFCS_UNLOCK_ADDR_B   16'h2AAA
`define PFCS_UNLOCK_DATA_A   16'h00AA
`define PFCS_UNLOCK_DATA_B   16'h0055
`define PFCS_CMD_SETUP       16'h0080
`define PFCS_CMD_CHIP_ERASE  16'h0010
`define PFCS_CMD_MAIN_ERASE  16'h0030
`define PFCS_CMD_LOCKOUT     16'h0040
`define PFCS_CMD_PROGRAM     16'h00A0
`define PFCS_CMD_ID_ENTRY    16'h0090
`define PFCS_CMD_ID_EXIT     16'h00F0
`define PFCS_LOCK_STAT_ADDR  16'h0002
`define PFCS_BOOT_LAST_ADDR  16'h1FFF
`define PFCS_ERASED_WORD     16'hFFFF
`define PFCS_POLL_BIT        7
`define PFCS_TOGGLE_BIT      6
`define PFCS_LOCK_BIT        0
// Strobe phase lengths in ns and the derived cycle counts at 8 ns per cycle.
`define PFCS_CLK_PERIOD_NS   8
`define PFCS_STROBE_LOW_NS   40
`define PFCS_SETUP_NS        16
`define PFCS_READ_NS         64
`define PFCS_STROBE_LOW_CYC  ((`PFCS_STROBE_LOW_NS + `PFCS_CLK_PERIOD_NS - 1) / `PFCS_CLK_PERIOD_NS)
`define PFCS_SETUP_CYC       ((`PFCS_SETUP_NS + `PFCS_CLK_PERIOD_NS - 1) / `PFCS_CLK_PERIOD_NS)
`define PFCS_READ_CYC        ((`PFCS_READ_NS + `PFCS_CLK_PERIOD_NS - 1) / `PFCS_CLK_PERIOD_NS)
`define PFCS_POLL_LIMIT      24'hFFFFFF
`define PFCS_SEQ_LEN_MAX     6
`endif

// ==== rtl/pfcs_pkg.sv ====
// Types shared by the flash command sequencer host.
package pfcs_pkg;
    typedef enum logic [2:0]
    {
        PFCS_OP_READ,
        PFCS_OP_PROGRAM,
        PFCS_OP_CHIP_ERASE,
        PFCS_OP_MAIN_ERASE,
        PFCS_OP_LOCKOUT,
        PFCS_OP_ID_ENTRY,
        PFCS_OP_ID_EXIT,
        PFCS_OP_ID_EXIT_SHORT
    } pfcs_op_type;

    typedef struct packed
    {
        pfcs_op_type op;
        logic [15:0] addr;
        logic [15:0] data;
    } pfcs_req_type;

    typedef struct packed
    {
        logic [15:0] data;
        logic        timeout;
        logic        refused;
    } pfcs_rsp_type;

    typedef struct packed
    {
        logic [15:0] addr;
        logic [15:0] data;
    } pfcs_cycle_type;
endpackage

// ==== rtl/pfcs_seq_rom.sv ====
// Small registered table of the unlock-coded write cycles of each command.
`timescale 1ns/100ps
`include "pfcs_params.svh"
module pfcs_seq_rom
(
    // Clock and lookup.
    input  wire logic                   clk,
    input  wire pfcs_pkg::pfcs_op_type  op,
    input  wire logic [2:0]             idx,
    input  wire logic [15:0]            user_addr,
    input  wire logic [15:0]            user_data,
    // Registered cycle.
    output      pfcs_pkg::pfcs_cycle_type cyc
);
    import pfcs_pkg::*;

    pfcs_cycle_type cyc_next;

    always_comb
    begin
        cyc_next = '{addr: `PFCS_UNLOCK_ADDR_A, data: `PFCS_UNLOCK_DATA_A};
        if (idx == 3'h1 || idx == 3'h4)
        begin
            cyc_next = '{addr: `PFCS_UNLOCK_ADDR_B, data: `PFCS_UNLOCK_DATA_B};
        end
        else if (idx == 3'h2)
        begin
            case (op)
                PFCS_OP_PROGRAM:  cyc_next.data = `PFCS_CMD_PROGRAM;   // [R9]
                PFCS_OP_ID_ENTRY: cyc_next.data = `PFCS_CMD_ID_ENTRY;  // [R16]
                PFCS_OP_ID_EXIT:  cyc_next.data = `PFCS_CMD_ID_EXIT;   // [R16]
                default:          cyc_next.data = `PFCS_CMD_SETUP;
            endcase
        end
        else if (idx == 3'h3 && op == PFCS_OP_PROGRAM)
        begin
            cyc_next = '{addr: user_addr, data: user_data};            // [R9]
        end
        else if (idx == 3'h5)
        begin
            case (op)
                PFCS_OP_CHIP_ERASE: cyc_next.data = `PFCS_CMD_CHIP_ERASE; // [R3]
                PFCS_OP_MAIN_ERASE: cyc_next.data = `PFCS_CMD_MAIN_ERASE; // [R6]
                default:            cyc_next.data = `PFCS_CMD_LOCKOUT;    // [R14]
            endcase
        end
        if (op == PFCS_OP_ID_EXIT_SHORT)
        begin
            cyc_next = '{addr: user_addr, data: `PFCS_CMD_ID_EXIT};       // [R16]
        end
    end

    always_ff @(posedge clk)
    begin
        cyc <= cyc_next;
    end
endmodule

// ==== rtl/pfcs_host.sv ====
// Host controller that drives a parallel flash through its strobe pins.
`timescale 1ns/100ps
`include "pfcs_params.svh"
// Overview of operation
// R1 - Read: select and output enable low
// R2 - Device floats data unless both low; the bench flash model drives the inverse of its last word instead
// R3 - Chip erase ends with 10 hex
// R4 - Device returns to read after erase
// R5 - Main erase clears non-boot words
// R6 - Main erase: six cycles, 30 last
// R7 - Device self-times erase after sixth cycle
// R8 - Program only clears bits
// R9 - Program: AA, 55, A0, then word
// R10 - Address on fall, data on rise
// R11 - Device times program internally
// R12 - Boot block is words 0 to 1FFF
// R13 - Lockout refuses boot program and erase
// R14 - Lockout: six cycles ending 40
// R15 - ID mode address 2 bit0 lock state
// R16 - ID entry 90, exit F0 forms
// R17 - Same ID codes either way
// R18 - Poll bit complements during program
// R19 - Toggle bit alternates while busy
// R20 - No write with output enable low
// R21 - Short strobe pulses ignored
// R22 - Only low byte, A14-A0 decoded
// R23 - Mismatched sequence is abandoned
// R24 - Writes ignored while device busy
module pfcs_host
#(
    parameter int POLL_LIMIT = `PFCS_POLL_LIMIT
)
(
    // Clock and reset.
    input  wire logic                   MCLK,
    input  wire logic                   SRST,
    // User request and answer.
    input  wire logic                   REQ_VALID,
    input  wire pfcs_pkg::pfcs_req_type REQ,
    output      logic                   REQ_READY,
    output      logic                   RSP_VALID,
    output      pfcs_pkg::pfcs_rsp_type RSP,
    output      logic                   LOCKED_KNOWN,
    // Flash pins.
    output      logic [15:0]            WORD_ADDRESS,
    output      logic                   CHIP_SEL_N,
    output      logic                   OUT_EN_N,
    output      logic                   WRITE_EN_N,
    input  wire logic [15:0]            DATA_LINES_IN,
    output      logic [15:0]            DATA_LINES_OUT,
    output      logic                   DATA_LINES_OE
);
    import pfcs_pkg::*;

    typedef enum
    {
        ST_IDLE,
        ST_FETCH,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD,
        ST_RD_SETUP,
        ST_RD_WAIT,
        ST_POLL_A,
        ST_POLL_B,
        ST_DONE
    } pfcs_state_type;

    localparam logic [7:0] STROBE_CYC = 8'(`PFCS_STROBE_LOW_CYC);
    localparam logic [7:0] SETUP_CYC  = 8'(`PFCS_SETUP_CYC);
    localparam logic [7:0] READ_CYC   = 8'(`PFCS_READ_CYC);

    pfcs_state_type state_reg;
    pfcs_req_type   req_reg;
    pfcs_cycle_type cyc;
    logic [2:0]     idx_reg;
    logic [7:0]     wait_reg;
    logic [23:0]    poll_reg;
    logic [15:0]    first_read_reg;
    logic           poll_second_reg;

    // Number of bus write cycles in each command sequence.
    function automatic logic [2:0] seq_len(input pfcs_op_type op);
        case (op)
            PFCS_OP_PROGRAM:       seq_len = 3'h4;
            PFCS_OP_ID_ENTRY:      seq_len = 3'h3;
            PFCS_OP_ID_EXIT:       seq_len = 3'h3;
            PFCS_OP_ID_EXIT_SHORT: seq_len = 3'h1;
            PFCS_OP_READ:          seq_len = 3'h0;
            default:               seq_len = 3'h6;
        endcase
    endfunction

    // True for operations the device self-times afterwards.
    function automatic logic is_timed(input pfcs_op_type op);
        is_timed = (op == PFCS_OP_PROGRAM) || (op == PFCS_OP_CHIP_ERASE) || (op == PFCS_OP_MAIN_ERASE);
    endfunction

    pfcs_seq_rom u_rom
    (
        .clk       (MCLK),
        .op        (req_reg.op),
        .idx       (idx_reg),
        .user_addr (req_reg.addr),
        .user_data (req_reg.data),
        .cyc       (cyc)
    );

    //--------------------------------------------------------------------
    // Request capture and sequencing.
    //--------------------------------------------------------------------
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            state_reg       <= ST_IDLE;
            req_reg         <= '0;
            idx_reg         <= 3'h0;
            wait_reg        <= 8'h00;
            poll_reg        <= 24'h000000;
            first_read_reg  <= 16'h0000;
            poll_second_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    idx_reg <= 3'h0;
                    if (REQ_VALID)
                    begin
                        req_reg   <= REQ;
                        // A program into a locked boot block is refused by the device; it is still sent.
                        state_reg <= (REQ.op == PFCS_OP_READ) ? ST_RD_SETUP : ST_FETCH;
                        wait_reg  <= (REQ.op == PFCS_OP_READ) ? READ_CYC : 8'h00;
                    end
                end
                ST_FETCH:
                begin
                    state_reg <= ST_SETUP;
                    wait_reg  <= SETUP_CYC;
                end
                ST_SETUP:
                begin
                    // Output enable stays high whenever a write strobe may fall.  [R20]
                    wait_reg <= wait_reg - 8'h01;
                    if (wait_reg == 8'h01)
                    begin
                        state_reg <= ST_STROBE;
                        wait_reg  <= STROBE_CYC;
                    end
                end
                ST_STROBE:
                begin
                    // Strobe low far beyond the noise filter width.  [R21]
                    wait_reg <= wait_reg - 8'h01;
                    if (wait_reg == 8'h01)
                    begin
                        state_reg <= ST_HOLD;
                        wait_reg  <= SETUP_CYC;
                    end
                end
                ST_HOLD:
                begin
                    wait_reg <= wait_reg - 8'h01;
                    if (wait_reg == 8'h01)
                    begin
                        idx_reg <= idx_reg + 3'h1;
                        if (idx_reg + 3'h1 == seq_len(req_reg.op))
                        begin
                            // Busy device is polled; no new command goes out until it settles or the POLL_LIMIT poll count runs out.  [R24]
                            state_reg <= is_timed(req_reg.op) ? ST_POLL_A : ST_DONE;
                            poll_reg  <= 24'h000000;
                            wait_reg  <= READ_CYC;
                        end
                        else
                        begin
                            state_reg <= ST_FETCH;
                        end
                    end
                end
                ST_RD_SETUP:
                begin
                    wait_reg <= wait_reg - 8'h01;
                    if (wait_reg == 8'h01)
                    begin
                        state_reg      <= ST_DONE;
                        first_read_reg <= DATA_LINES_IN;                  // [R1]
                    end
                end
                ST_POLL_A:
                begin
                    wait_reg <= wait_reg - 8'h01;
                    if (wait_reg == 8'h01)
                    begin
                        first_read_reg  <= DATA_LINES_IN;
                        poll_second_reg <= 1'b1;
                        state_reg       <= ST_POLL_B;
                        wait_reg        <= READ_CYC;
                    end
                end
                ST_POLL_B:
                begin
                    wait_reg <= wait_reg - 8'h01;
                    if (wait_reg == 8'h01)
                    begin
                        poll_reg <= poll_reg + 24'h000001;
                        // Equal toggle bits in two successive reads mean the toggle bit stopped.  [R19]
                        if (DATA_LINES_IN[`PFCS_TOGGLE_BIT] == first_read_reg[`PFCS_TOGGLE_BIT]
                            || poll_reg == 24'(POLL_LIMIT))
                        begin
                            state_reg <= ST_DONE;
                        end
                        else
                        begin
                            state_reg <= ST_POLL_A;
                        end
                        first_read_reg <= DATA_LINES_IN;
                        wait_reg       <= READ_CYC;
                    end
                end
                default:
                begin
                    state_reg       <= ST_IDLE;
                    poll_second_reg <= 1'b0;
                end
            endcase
        end
    end

    //--------------------------------------------------------------------
    // Pin drive.
    //--------------------------------------------------------------------
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            CHIP_SEL_N     <= 1'b1;
            OUT_EN_N       <= 1'b1;
            WRITE_EN_N     <= 1'b1;
            WORD_ADDRESS   <= 16'h0000;
            DATA_LINES_OUT <= 16'h0000;
            DATA_LINES_OE  <= 1'b0;
        end
        else
        begin
            CHIP_SEL_N    <= !(state_reg == ST_SETUP || state_reg == ST_STROBE || state_reg == ST_RD_SETUP
                               || state_reg == ST_POLL_A || state_reg == ST_POLL_B);
            // Reads drop output enable only with write strobe high.  [R1] [R2]
            // Output enable rises after each status sample so that every poll read is a new access.  [R19]
            OUT_EN_N      <= !(state_reg == ST_RD_SETUP
                               || ((state_reg == ST_POLL_A || state_reg == ST_POLL_B) && wait_reg != 8'h01));
            // Address latches on the strobe fall and data on its rise.  [R10] [R6]
            WRITE_EN_N    <= !(state_reg == ST_STROBE && wait_reg != 8'h01);
            DATA_LINES_OE <= (state_reg == ST_SETUP || state_reg == ST_STROBE || state_reg == ST_HOLD);
            if (state_reg == ST_SETUP)
            begin
                // High data byte and address bit 15 are don't-care; sent as given.  [R22]
                WORD_ADDRESS   <= cyc.addr;
                DATA_LINES_OUT <= cyc.data;
            end
            else if (state_reg == ST_IDLE && REQ_VALID && REQ.op == PFCS_OP_READ)
            begin
                WORD_ADDRESS <= REQ.addr;
            end
            else if (state_reg == ST_HOLD && wait_reg == 8'h01 && req_reg.op == PFCS_OP_PROGRAM)
            begin
                // Poll the last loaded word so the complement bit is visible.  [R18]
                WORD_ADDRESS <= req_reg.addr;
            end
        end
    end

    //--------------------------------------------------------------------
    // Answer to the user.
    //--------------------------------------------------------------------
    always_ff @(posedge MCLK)
    begin
        if (SRST)
        begin
            REQ_READY    <= 1'b0;
            RSP_VALID    <= 1'b0;
            RSP          <= '0;
            LOCKED_KNOWN <= 1'b0;
        end
        else
        begin
            REQ_READY <= (state_reg == ST_IDLE) && !REQ_VALID;
            RSP_VALID <= (state_reg == ST_DONE);
            if (state_reg == ST_DONE)
            begin
                RSP.data    <= first_read_reg;
                RSP.timeout <= poll_second_reg && (poll_reg > 24'(POLL_LIMIT));
                // Program into boot region is flagged refused once LOCKED_KNOWN is set; erase there leaves data, seen only on verify.  [R13] [R12]
                RSP.refused <= (req_reg.op == PFCS_OP_PROGRAM) && (req_reg.addr <= `PFCS_BOOT_LAST_ADDR)
                               && LOCKED_KNOWN;
            end
            if (state_reg == ST_DONE && req_reg.op == PFCS_OP_LOCKOUT)
            begin
                LOCKED_KNOWN <= 1'b1;                                     // [R14]
            end
            else if (state_reg == ST_DONE && req_reg.op == PFCS_OP_READ
                     && req_reg.addr == `PFCS_LOCK_STAT_ADDR)
            begin
                LOCKED_KNOWN <= LOCKED_KNOWN | first_read_reg[`PFCS_LOCK_BIT];  // [R15]
            end
        end
    end
endmodule

// ==== bench/pfcs_flash_model.sv ====
// Behavioural parallel flash with command decoder, busy timer and status bits.
`timescale 1ns/100ps
module pfcs_flash_model
#(
    parameter logic [15:0] MFR_CODE = 16'h0A5C, // Arbitrary value.
    parameter logic [15:0] DEV_CODE = 16'h0C3A, // Arbitrary value.
    parameter int          PROG_NS  = 2000,
    parameter int          ERASE_NS = 4000
)
(
    // Flash pins.
    input  wire logic [15:0] word_address,
    input  wire logic        chip_sel_n,
    input  wire logic        out_en_n,
    input  wire logic        write_en_n,
    input  wire logic [15:0] data_in,
    output      logic [15:0] data_out
);
    logic [15:0] mem [0:65535];
    logic [15:0] lat_a, pd, rd;
    logic [15:0] last = 16'h0000;
    logic        busy = 1'b0;
    logic        tog = 1'b0;
    logic        id = 1'b0;
    logic        locked = 1'b0;
    int          step = 0;
    int          dur = 0;
    realtime     t_fall = 0.0;

    initial
        foreach (mem[i]) mem[i] = 16'hFFFF;

    task start(input int ns, input logic [15:0] w);
        dur = ns;
        pd = w;
        busy = 1'b1;
    endtask

    // Only the low data byte and the low fifteen address bits take part in decoding.
    task decode(input logic [14:0] a, input logic [7:0] d, input logic [15:0] w);
        if (step == 3)
        begin
            if (!locked || lat_a > 16'h1FFF)
                mem[lat_a] = mem[lat_a] & w;
            start(PROG_NS, w);
            step = 0;
        end
        else if (d == 8'hF0)
        begin
            id = 1'b0;
            step = 0;
        end
        else if (step == 0 || step == 4)
            step = (a == 15'h5555 && d == 8'hAA) ? step + 1 : 0;
        else if (step == 1 || step == 5)
            step = (a == 15'h2AAA && d == 8'h55) ? step + 1 : 0;
        else if (step == 2)
        begin
            id = id | (a == 15'h5555 && d == 8'h90);
            step = a != 15'h5555 ? 0 : d == 8'hA0 ? 3 : d == 8'h80 ? 4 : 0;
        end
        else
        begin
            step = 0;
            if (a == 15'h5555 && d == 8'h40)
                locked = 1'b1;
            if (a == 15'h5555 && (d == 8'h10 || d == 8'h30))
            begin
                for (int i = 16'h2000; i < 65536; i++) mem[i] = 16'hFFFF;
                if (d == 8'h10 && !locked)
                    for (int i = 0; i < 16'h2000; i++) mem[i] = 16'hFFFF;
                start(ERASE_NS, 16'hFFFF);
            end
        end
    endtask

    always @(negedge write_en_n)
        if (!chip_sel_n)
        begin
            lat_a = word_address;
            t_fall = $realtime;
        end

    always @(posedge write_en_n)
        if (!chip_sel_n && out_en_n && !busy && $realtime - t_fall >= 15.0)
            decode(lat_a[14:0], data_in[7:0], data_in);

    always @(posedge busy)
        #(dur) busy = 1'b0;

    always @(negedge out_en_n)
        if (busy)
            tog = ~tog;

    always_comb
        if (busy)
            rd = {pd[15:8], ~pd[7], tog, pd[5:0]};
        else if (id && word_address == 16'h0002)
            rd = {15'h0000, locked};
        else if (id && word_address < 16'h0002)
            rd = word_address[0] ? DEV_CODE : MFR_CODE;
        else
            rd = mem[word_address];

    // A released bus shows the inverse of the last driven word, never a stale copy.
    always @(posedge out_en_n or posedge chip_sel_n)
        last = rd;

    assign data_out = (!chip_sel_n && !out_en_n && write_en_n) ? rd : ~last;
endmodule

// ==== bench/pfcs_host_asserts.sv ====
// Protocol checks on the flash pins and the answer port of the host.
`timescale 1ns/100ps
module pfcs_host_asserts
(
    // Clock and reset.
    input wire logic        MCLK,
    input wire logic        SRST,
    // Observed ports.
    input wire logic        RSP_VALID,
    input wire logic [15:0] WORD_ADDRESS,
    input wire logic        CHIP_SEL_N,
    input wire logic        OUT_EN_N,
    input wire logic        WRITE_EN_N,
    input wire logic [15:0] DATA_LINES_OUT,
    input wire logic        DATA_LINES_OE
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (SRST);

    sequence we_low_phase;
        !WRITE_EN_N [*3] ##1 WRITE_EN_N;
    endsequence

    sequence cs_hold_phase;
        !CHIP_SEL_N && DATA_LINES_OE ##1 DATA_LINES_OE [*2];
    endsequence

    no_wr_read_a: assert property (!(!WRITE_EN_N && !OUT_EN_N))
        else $error("write and output strobes low together");
    we_in_cs_a: assert property (!WRITE_EN_N |-> !CHIP_SEL_N)
        else $error("write strobe low without chip select");
    we_width_a: assert property ($fell(WRITE_EN_N) |=> we_low_phase)
        else $error("write strobe pulse has wrong width");
    data_hold_a: assert property ($rose(WRITE_EN_N) |-> cs_hold_phase)
        else $error("chip select rose before write strobe");
    addr_stable_a: assert property (!WRITE_EN_N |-> $stable(WORD_ADDRESS) && $stable(DATA_LINES_OUT))
        else $error("address or data moved while write strobe low");
    wr_drive_a: assert property (!WRITE_EN_N |-> DATA_LINES_OE)
        else $error("data lines not driven during write");
    rd_float_a: assert property (!OUT_EN_N |-> !DATA_LINES_OE && WRITE_EN_N)
        else $error("host drives data lines during read");
    rsp_pulse_a: assert property (RSP_VALID |=> !RSP_VALID)
        else $error("answer valid longer than one cycle");
    reset_idle_a: assert property (disable iff (1'b0) SRST |=> CHIP_SEL_N && WRITE_EN_N && OUT_EN_N && !DATA_LINES_OE)
        else $error("pins not idle after reset");
endmodule

bind pfcs_host pfcs_host_asserts u_asserts (.*);

// ==== bench/pfcs_host_bench.sv ====
// Self-checking bench of the flash host against a behavioural flash.
`timescale 1ns/100ps
module pfcs_host_bench;
    import pfcs_pkg::*;
    localparam logic [15:0] MFR = 16'h0A5C; // Arbitrary value.
    localparam logic [15:0] DEV = 16'h0C3A; // Arbitrary value.
    logic         MCLK = 1'b0;
    logic         SRST = 1'b1;
    logic         REQ_VALID = 1'b0;
    pfcs_req_type REQ = '0;
    pfcs_rsp_type RSP;
    logic         REQ_READY, RSP_VALID, LOCKED_KNOWN, CHIP_SEL_N, OUT_EN_N, WRITE_EN_N, DATA_LINES_OE;
    logic [15:0]  WORD_ADDRESS, DATA_LINES_IN, DATA_LINES_OUT;
    int           errors = 0;
    int           cmp_count = 0;

    pfcs_host #(.POLL_LIMIT(100)) u_dut (.MCLK, .SRST, .REQ_VALID, .REQ, .REQ_READY, .RSP_VALID, .RSP,
        .LOCKED_KNOWN, .WORD_ADDRESS, .CHIP_SEL_N, .OUT_EN_N, .WRITE_EN_N, .DATA_LINES_IN,
        .DATA_LINES_OUT, .DATA_LINES_OE);
    pfcs_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_flash (.word_address(WORD_ADDRESS),
        .chip_sel_n(CHIP_SEL_N), .out_en_n(OUT_EN_N), .write_en_n(WRITE_EN_N),
        .data_in(DATA_LINES_OUT), .data_out(DATA_LINES_IN));

    initial
        forever #4 MCLK = ~MCLK;

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // One request, held for a single taking edge, then a bounded wait for the answer.
    task automatic issue(input pfcs_op_type op, input logic [15:0] a, input logic [15:0] d);
        int n;
        n = 0;
        while (REQ_READY !== 1'b1 && n < 100)
        begin
            @(negedge MCLK);
            n++;
        end
        check("ready", 16'h0001, {15'h0000, REQ_READY});
        REQ_VALID = 1'b1;
        REQ = '{op, a, d};
        @(negedge MCLK);
        REQ_VALID = 1'b0;
        n = 0;
        while (RSP_VALID !== 1'b1 && n < 20000)
        begin
            @(negedge MCLK);
            n++;
        end
        check("answer", 16'h0001, {15'h0000, RSP_VALID});
        check("timeout flag", 16'h0000, {15'h0000, RSP.timeout});
    endtask

    task automatic rd_chk(input string what, input logic [15:0] a, input logic [15:0] exp);
        issue(PFCS_OP_READ, a, 16'h0000);
        check(what, exp, RSP.data);
    endtask

    task automatic t_reset();
        check("idle strobes", 16'h0007, {13'h0000, CHIP_SEL_N, OUT_EN_N, WRITE_EN_N});
        check("idle drive", 16'h0000, {15'h0000, DATA_LINES_OE});
        check("lock known", 16'h0000, {15'h0000, LOCKED_KNOWN});
        rd_chk("blank word", 16'h3000, 16'hFFFF);
        $display("test reset done");
    endtask

    task automatic t_program();
        issue(PFCS_OP_PROGRAM, 16'h3000, 16'h1234);
        check("poll word", 16'h1234, RSP.data);
        rd_chk("programmed", 16'h3000, 16'h1234);
        issue(PFCS_OP_PROGRAM, 16'h3000, 16'hFF0F);
        rd_chk("bits only cleared", 16'h3000, 16'h1204);
        $display("test program done");
    endtask

    task automatic t_ident();
        issue(PFCS_OP_ID_ENTRY, 16'h0000, 16'h0000);
        rd_chk("lock state", 16'h0002, 16'h0000);
        rd_chk("maker code", 16'h0000, MFR);
        rd_chk("device code", 16'h0001, DEV);
        issue(PFCS_OP_ID_EXIT_SHORT, 16'h8123, 16'h0000);
        rd_chk("array after exit", 16'h3000, 16'h1204);
        $display("test ident done");
    endtask

    task automatic t_erase();
        issue(PFCS_OP_PROGRAM, 16'h1FFF, 16'h00F0);
        issue(PFCS_OP_MAIN_ERASE, 16'h0000, 16'h0000);
        rd_chk("main erased", 16'h3000, 16'hFFFF);
        rd_chk("boot kept", 16'h1FFF, 16'h00F0);
        issue(PFCS_OP_CHIP_ERASE, 16'h0000, 16'h0000);
        rd_chk("boot erased", 16'h1FFF, 16'hFFFF);
        issue(PFCS_OP_PROGRAM, 16'h0010, 16'h00F0);
        rd_chk("boot programmed", 16'h0010, 16'h00F0);
        $display("test erase done");
    endtask

    task automatic t_lockout();
        issue(PFCS_OP_LOCKOUT, 16'h0000, 16'h0000);
        check("lock known", 16'h0001, {15'h0000, LOCKED_KNOWN});
        issue(PFCS_OP_ID_ENTRY, 16'h0000, 16'h0000);
        rd_chk("lock state", 16'h0002, 16'h0001);
        issue(PFCS_OP_ID_EXIT, 16'h0000, 16'h0000);
        issue(PFCS_OP_PROGRAM, 16'h0010, 16'h0000);
        check("refused", 16'h0001, {15'h0000, RSP.refused});
        rd_chk("boot locked", 16'h0010, 16'h00F0);
        issue(PFCS_OP_PROGRAM, 16'h3000, 16'h0000);
        check("refused", 16'h0000, {15'h0000, RSP.refused});
        issue(PFCS_OP_CHIP_ERASE, 16'h0000, 16'h0000);
        rd_chk("main erased", 16'h3000, 16'hFFFF);
        rd_chk("boot kept", 16'h0010, 16'h00F0);
        $display("test lockout done");
    endtask

    initial
    begin
        repeat (60000) @(posedge MCLK);
        errors++;
        test_done();
    end

    initial
    begin
        repeat (16) @(negedge MCLK);
        SRST = 1'b0;
        repeat (2) @(negedge MCLK);
        t_reset();
        t_program();
        t_ident();
        t_erase();
        t_lockout();
        test_done();
    end
endmodule
